// file: hw/frsc_consts.vh
// Constants of the framer receive signaling and counter bank
// Operation
// - E1: first word upper nibble zero
// - Extended superframe reports A-D per channel
// - Twelve-frame superframe copies A,B into C,D
// - Signaling frozen while frame sync lost
// - Line code violation count at 050h/051h
// - Path code violation count at 052h/053h
// - Sync loss frame count at 054h/055h
// - E-bit count, E1 only, 056h/057h
// - Far-end A count at 058h/059h
// - Far-end B count at 05Ah/05Bh
// - Eight ports, stride 200h
// - Monitor byte at 060h, first bit MSB
// - Monitor follows channel select register
`ifndef FRSC_CONSTS_VH
`define FRSC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices within a port block (byte address = 4 x index)
// ----------------------------------------------------------------
`define FRSC_PORT_STRIDE 12'h200
`define FRSC_IDX_SIG_BASE 7'h40
`define FRSC_IDX_LCV_HI 7'h50
`define FRSC_IDX_LCV_LO 7'h51
`define FRSC_IDX_PCV_HI 7'h52
`define FRSC_IDX_PCV_LO 7'h53
`define FRSC_IDX_FOS_HI 7'h54
`define FRSC_IDX_FOS_LO 7'h55
`define FRSC_IDX_EBIT_HI 7'h56
`define FRSC_IDX_EBIT_LO 7'h57
`define FRSC_IDX_FEA_HI 7'h58
`define FRSC_IDX_FEA_LO 7'h59
`define FRSC_IDX_FEB_HI 7'h5a
`define FRSC_IDX_FEB_LO 7'h5b
`define FRSC_IDX_MON 7'h60
`define FRSC_IDX_CTL 7'h70
`define FRSC_IDX_CHSEL 7'h71
`define FRSC_IDX_INT_STAT 7'h72
`define FRSC_IDX_INT_MASK 7'h73

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FRSC_CTL_E1_BIT 0
`define FRSC_CTL_ESF_BIT 1
`define FRSC_CTL_RESET 2'h0
`define FRSC_CHSEL_RESET 5'h00
`define FRSC_CNT_RESET 16'h0000
`define FRSC_CNT_MAX 16'hffff
`define FRSC_BYTE_RESET 8'h00
`define FRSC_NUM_CNT 6

// ----------------------------------------------------------------
// Host signaling poll periods (obligation of software)
// ----------------------------------------------------------------
`define FRSC_CLK_MHZ 40
`define FRSC_POLL_D4_US 1500
`define FRSC_POLL_ESF_US 3000
`define FRSC_POLL_D4_CYC (`FRSC_POLL_D4_US * `FRSC_CLK_MHZ)
`define FRSC_POLL_ESF_CYC (`FRSC_POLL_ESF_US * `FRSC_CLK_MHZ)

`endif

// file: hw/frsc_sig_mem.v
// Signaling word store: nibble-writable, registered read
`timescale 1ns/1ps
`default_nettype none
module frsc_sig_mem #(
  parameter AW = 7
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Write side
  input wire wen,
  input wire [AW-1:0] waddr,
  input wire whi,
  input wire [3:0] wdata,
  // Read side
  input wire ren,
  input wire [AW-1:0] raddr,
  output reg [7:0] rdata_q
);

  reg [7:0] mem [0:(1<<AW)-1];

  // Nibble write; storage has no reset, contents are line data
  always @(posedge hclk) begin
    if (wen) begin
      if (whi) begin
        mem[waddr] <= {wdata, mem[waddr][3:0]};
      end else begin
        mem[waddr] <= {mem[waddr][7:4], wdata};
      end
    end
  end

  // Registered read port
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 8'h00;
    end else if (ren) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule // frsc_sig_mem
`default_nettype wire

// file: hw/frsc_top.v
// Receive signaling, performance counters and monitor byte bank
`timescale 1ns/1ps
`default_nettype none
`include "frsc_consts.vh"
module frsc_top #(
  parameter NPORTS = 8
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Interrupt
  output reg irq,
  // Line events, one bit per port, one-cycle pulses
  input wire [NPORTS-1:0] line_code_viol_evt,
  input wire [NPORTS-1:0] path_code_viol_evt,
  input wire [NPORTS-1:0] sync_loss_frame_evt,
  input wire [NPORTS-1:0] ebit_evt,
  input wire [NPORTS-1:0] far_end_a_evt,
  input wire [NPORTS-1:0] far_end_b_evt,
  // Frame sync state, one bit per port
  input wire [NPORTS-1:0] frame_sync_lost,
  // Received signaling update
  input wire sig_upd,
  input wire [2:0] sig_port,
  input wire [4:0] sig_chan,
  input wire [3:0] sig_abcd,
  // Received channel bits for the monitor
  input wire mon_bit_en,
  input wire [2:0] mon_port,
  input wire [4:0] mon_chan,
  input wire mon_bit,
  input wire mon_last
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;
  localparam NCNT = NPORTS * `FRSC_NUM_CNT;

  reg [1:0] state_q;
  reg [2:0] aport_q;
  reg [6:0] areg_q;
  reg aok_q;
  reg wr_pend_q;
  reg [1:0] ctl_q [0:NPORTS-1];
  reg [4:0] chsel_q [0:NPORTS-1];
  reg [7:0] mon_sh_q [0:NPORTS-1];
  reg [7:0] mon_q [0:NPORTS-1];
  reg [15:0] cnt_q [0:NCNT-1];
  reg [15:0] snap_q;
  reg [5:0] snap_id_q;
  reg snap_ok_q;
  reg [NPORTS-1:0] int_stat_q;
  reg [NPORTS-1:0] int_mask_q;
  reg [7:0] rd_byte;
  integer p;
  integer pw;
  integer pm;
  integer c;

  wire [7:0] sig_rdata;
  wire [2:0] h_port;
  wire [8:0] h_reg;
  wire h_ok;
  wire h_take;
  wire [5:0] sig_loc;
  wire [1:0] sig_mode;
  wire sig_take;
  wire [3:0] sig_nib;
  wire [6:0] cnt_off;
  wire [2:0] cnt_sel;
  wire [5:0] cnt_id;
  wire is_cnt;
  wire is_cnt_hi;
  wire rd_stat;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Channel to {valid, high nibble, word index} for the current mode
  function [5:0] sig_map;
    input [4:0] ch;
    input e1;
    begin
      sig_map = 6'h00;
      if (e1) begin
        if (ch == 5'd0) begin
          sig_map = {1'b1, 1'b0, 4'd0};
        end else if (ch <= 5'd15) begin
          sig_map = {1'b1, 1'b1, ch[3:0]};
        end else if (ch <= 5'd30) begin
          sig_map = {1'b1, 1'b0, ch[3:0] - 4'd15};
        end
      end else begin
        if (ch >= 5'd1 && ch <= 5'd12) begin
          sig_map = {1'b1, 1'b1, ch[3:0] - 4'd1};
        end else if (ch >= 5'd13 && ch <= 5'd24) begin
          sig_map = {1'b1, 1'b0, ch[3:0] - 4'd13};
        end
      end
    end
  endfunction

  // Flat counter index from port and counter number
  function [5:0] cnt_index;
    input [2:0] port;
    input [2:0] num;
    begin
      cnt_index = ({3'b000, port} << 2) + ({3'b000, port} << 1) + {3'b000, num};
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Byte address = 4 x (port x 200h + index)
  assign h_port = haddr[13:11];
  assign h_reg = haddr[10:2];
  assign h_ok = (haddr[31:14] == 18'h0_0000) && ({1'b0, h_port} < NPORTS) &&
                (h_reg[8:7] == 2'b00);
  assign h_take = hsel && htrans[1] && hready;

  // Counter decode of the captured address
  assign is_cnt = aok_q && (areg_q >= `FRSC_IDX_LCV_HI) && (areg_q <= `FRSC_IDX_FEB_LO);
  assign cnt_off = areg_q - `FRSC_IDX_LCV_HI;
  assign cnt_sel = cnt_off[3:1];
  assign is_cnt_hi = ~areg_q[0];
  assign cnt_id = cnt_index(aport_q, cnt_sel);
  assign rd_stat = (state_q == ST_READ) && aok_q && (aport_q == 3'd0) &&
                   (areg_q == `FRSC_IDX_INT_STAT);

  // ----------------------------------------------------------------
  // Signaling capture
  // ----------------------------------------------------------------
  assign sig_mode = ctl_q[sig_port];
  assign sig_loc = sig_map(sig_chan, sig_mode[`FRSC_CTL_E1_BIT]);
  // Frozen while out of sync; last good values stay visible
  assign sig_take = sig_upd && ({1'b0, sig_port} < NPORTS) && sig_loc[5] &&
                    !frame_sync_lost[sig_port];
  // Twelve-frame superframe has only A and B, repeated into C and D
  assign sig_nib = (!sig_mode[`FRSC_CTL_E1_BIT] && !sig_mode[`FRSC_CTL_ESF_BIT]) ?
                   {sig_abcd[3:2], sig_abcd[3:2]} : sig_abcd;

  frsc_sig_mem #(
    .AW(7)
  ) u_sig_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wen(sig_take),
    .waddr({sig_port, sig_loc[3:0]}),
    .whi(sig_loc[4]),
    .wdata(sig_nib),
    .ren(h_take && !hwrite),
    .raddr({h_port, h_reg[3:0]}),
    .rdata_q(sig_rdata)
  );

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Reads take one wait state so the memory and mux output is registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      aport_q <= 3'h0;
      areg_q <= 7'h00;
      aok_q <= 1'b0;
      wr_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          wr_pend_q <= h_take && hwrite;
          if (h_take) begin
            aport_q <= h_port;
            areg_q <= h_reg[6:0];
            aok_q <= h_ok;
          end
          if (h_take && !hwrite) begin
            hreadyout <= 1'b0;
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          hrdata <= {24'h00_0000, rd_byte};
          hreadyout <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          hreadyout <= 1'b1;
          wr_pend_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped and reserved locations read zero
  always @* begin
    rd_byte = 8'h00;
    if (aok_q) begin
      if (areg_q[6:4] == 3'b100) begin
        rd_byte = sig_rdata;
        if (areg_q[3:0] == 4'd0 && ctl_q[aport_q][`FRSC_CTL_E1_BIT]) begin
          rd_byte = {4'h0, sig_rdata[3:0]};
        end
      end else if (is_cnt) begin
        if (is_cnt_hi) begin
          rd_byte = cnt_q[cnt_id][15:8];
        end else if (snap_ok_q && snap_id_q == cnt_id) begin
          rd_byte = snap_q[7:0];
        end else begin
          rd_byte = cnt_q[cnt_id][7:0];
        end
      end else if (areg_q == `FRSC_IDX_MON) begin
        rd_byte = mon_q[aport_q];
      end else if (areg_q == `FRSC_IDX_CTL) begin
        rd_byte = {6'h00, ctl_q[aport_q]};
      end else if (areg_q == `FRSC_IDX_CHSEL) begin
        rd_byte = {3'h0, chsel_q[aport_q]};
      end else if (aport_q == 3'd0 && areg_q == `FRSC_IDX_INT_STAT) begin
        for (c = 0; c < NPORTS; c = c + 1) begin
          rd_byte[c] = int_stat_q[c];
        end
      end else if (aport_q == 3'd0 && areg_q == `FRSC_IDX_INT_MASK) begin
        for (c = 0; c < NPORTS; c = c + 1) begin
          rd_byte[c] = int_mask_q[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter snapshot
  // ----------------------------------------------------------------
  // High-byte read freezes the low byte so a hi/lo pair is coherent
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_q <= `FRSC_CNT_RESET;
      snap_id_q <= 6'h00;
      snap_ok_q <= 1'b0;
    end else if (state_q == ST_READ && is_cnt) begin
      if (is_cnt_hi) begin
        snap_q <= cnt_q[cnt_id];
        snap_id_q <= cnt_id;
        snap_ok_q <= 1'b1;
      end else begin
        snap_ok_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable control registers
  // ----------------------------------------------------------------
  // Only control, select and mask take writes; counters ignore them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (pw = 0; pw < NPORTS; pw = pw + 1) begin
        ctl_q[pw] <= `FRSC_CTL_RESET;
        chsel_q[pw] <= `FRSC_CHSEL_RESET;
      end
      int_mask_q <= {NPORTS{1'b0}};
    end else if (wr_pend_q && aok_q) begin
      if (areg_q == `FRSC_IDX_CTL) begin
        ctl_q[aport_q] <= hwdata[1:0];
      end
      if (areg_q == `FRSC_IDX_CHSEL) begin
        chsel_q[aport_q] <= hwdata[4:0];
      end
      if (aport_q == 3'd0 && areg_q == `FRSC_IDX_INT_MASK) begin
        int_mask_q <= hwdata[NPORTS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Performance counters
  // ----------------------------------------------------------------
  // Counters saturate rather than wrap so a missed poll is visible
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (p = 0; p < NCNT; p = p + 1) begin
        cnt_q[p] <= `FRSC_CNT_RESET;
      end
    end else begin
      for (p = 0; p < NPORTS; p = p + 1) begin
        if (line_code_viol_evt[p] && cnt_q[p * 6] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6] <= cnt_q[p * 6] + 16'h0001;
        end
        if (path_code_viol_evt[p] && cnt_q[p * 6 + 1] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6 + 1] <= cnt_q[p * 6 + 1] + 16'h0001;
        end
        if (sync_loss_frame_evt[p] && cnt_q[p * 6 + 2] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6 + 2] <= cnt_q[p * 6 + 2] + 16'h0001;
        end
        if (ebit_evt[p] && ctl_q[p][`FRSC_CTL_E1_BIT] &&
            cnt_q[p * 6 + 3] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6 + 3] <= cnt_q[p * 6 + 3] + 16'h0001;
        end
        if (far_end_a_evt[p] && cnt_q[p * 6 + 4] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6 + 4] <= cnt_q[p * 6 + 4] + 16'h0001;
        end
        if (far_end_b_evt[p] && cnt_q[p * 6 + 5] != `FRSC_CNT_MAX) begin
          cnt_q[p * 6 + 5] <= cnt_q[p * 6 + 5] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel monitor
  // ----------------------------------------------------------------
  // First bit of the channel lands in bit 7, last in bit 0
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (pm = 0; pm < NPORTS; pm = pm + 1) begin
        mon_sh_q[pm] <= `FRSC_BYTE_RESET;
        mon_q[pm] <= `FRSC_BYTE_RESET;
      end
    end else if (mon_bit_en && ({1'b0, mon_port} < NPORTS) &&
                 mon_chan == chsel_q[mon_port]) begin
      mon_sh_q[mon_port] <= {mon_sh_q[mon_port][6:0], mon_bit};
      if (mon_last) begin
        mon_q[mon_port] <= {mon_sh_q[mon_port][6:0], mon_bit};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  // Per-port bit set on each accepted signaling update; a read clears,
  // but an update in the same cycle wins over the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_q <= {NPORTS{1'b0}};
      irq <= 1'b0;
    end else begin
      int_stat_q <= (rd_stat ? {NPORTS{1'b0}} : int_stat_q) |
                    (sig_take ? (({{(NPORTS-1){1'b0}}, 1'b1}) << sig_port) :
                     {NPORTS{1'b0}});
      irq <= |(int_stat_q & int_mask_q);
    end
  end

endmodule // frsc_top
`default_nettype wire

// file: verification/frsc_assertions.sv
// Checker of bus timing and read values of the signaling and counter bank
`timescale 1ns/1ps
`default_nettype none
module frsc_assertions #(
  parameter NPORTS = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  // Line inputs
  input wire logic [NPORTS-1:0] line_code_viol_evt,
  input wire logic [NPORTS-1:0] path_code_viol_evt,
  input wire logic [NPORTS-1:0] sync_loss_frame_evt,
  input wire logic [NPORTS-1:0] ebit_evt,
  input wire logic [NPORTS-1:0] far_end_a_evt,
  input wire logic [NPORTS-1:0] far_end_b_evt,
  input wire logic mon_bit_en
);
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Taken transfers and line activity
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire wr_take = hsel && htrans[1] && hready && hwrite;
  wire [8:0] idx = haddr[10:2];
  wire any_evt = |{line_code_viol_evt, path_code_viol_evt, sync_loss_frame_evt, ebit_evt,
                   far_end_a_evt, far_end_b_evt, mon_bit_en};
  wire cnt_idx = (idx >= 9'h050 && idx <= 9'h05b) || idx == 9'h060;
  logic seen_q;

  // Sticky: counts may be nonzero only after some line activity
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
    end else if (any_evt) begin
      seen_q <= 1'b1;
    end
  end

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_ready_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_rdata_stands: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (
    rd_take && idx >= 9'h061 && idx <= 9'h06f |-> ##2 hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_fresh_zero: assert property (
    rd_take && cnt_idx && !seen_q && !any_evt |-> ##2 (seen_q || hrdata == 32'h0000_0000))
    else $error("counter not zero after reset");

  c_read: cover property (rd_take && cnt_idx);
  c_write: cover property (wr_take);
  c_irq: cover property ($rose(irq));
endmodule // frsc_assertions

bind frsc_top frsc_assertions #(.NPORTS(NPORTS)) i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq, .line_code_viol_evt,
  .path_code_viol_evt, .sync_loss_frame_evt, .ebit_evt, .far_end_a_evt, .far_end_b_evt,
  .mon_bit_en);
`default_nettype wire

// file: verification/frsc_line_model.sv
// Line-side model: error events, signaling updates and monitor bits
`timescale 1ns/1ps
`default_nettype none
module frsc_line_model (
  // Clock
  input wire logic hclk,
  // Error events and frame state, one bit per port
  output logic [7:0] evt [0:5],
  output logic [7:0] frame_sync_lost,
  // Signaling updates
  output logic sig_upd,
  output logic [2:0] sig_port,
  output logic [4:0] sig_chan,
  output logic [3:0] sig_abcd,
  // Monitor bits
  output logic mon_bit_en,
  output logic [2:0] mon_port,
  output logic [4:0] mon_chan,
  output logic mon_bit,
  output logic mon_last
);
  // Quiet line at time zero
  initial begin
    for (int k = 0; k < 6; k++) begin
      evt[k] = 8'h00;
    end
    frame_sync_lost = 8'h00;
    sig_upd = 1'b0;
    sig_port = 3'h0;
    sig_chan = 5'h00;
    sig_abcd = 4'h0;
    mon_bit_en = 1'b0;
    mon_port = 3'h0;
    mon_chan = 5'h00;
    mon_bit = 1'b0;
    mon_last = 1'b0;
  end

  // Error pulses held n cycles back to back, so each cycle counts once
  task automatic burst(input int k, input int p, input int n);
    @(posedge hclk);
    evt[k][p-1] <= 1'b1;
    repeat (n - 1) @(posedge hclk);
    @(posedge hclk);
    evt[k][p-1] <= 1'b0;
  endtask

  // Frame sync state of one port
  task automatic set_lost(input int p, input logic v);
    @(posedge hclk);
    frame_sync_lost[p-1] <= v;
  endtask

  // One signaling update; stale data is inverted once the strobe drops
  task automatic sig(input int p, input int ch, input logic [3:0] abcd);
    @(posedge hclk);
    sig_upd <= 1'b1;
    sig_port <= 3'(p - 1);
    sig_chan <= 5'(ch);
    sig_abcd <= abcd;
    @(posedge hclk);
    sig_upd <= 1'b0;
    sig_abcd <= ~abcd;
  endtask

  // Channel byte sent first bit first, the last bit flagged
  task automatic mon(input int p, input int ch, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      mon_bit_en <= 1'b1;
      mon_port <= 3'(p - 1);
      mon_chan <= 5'(ch);
      mon_bit <= b[7-i];
      mon_last <= (i == 7);
    end
    @(posedge hclk);
    mon_bit_en <= 1'b0;
    mon_last <= 1'b0;
    mon_bit <= ~b[0];
  endtask
endmodule // frsc_line_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the signaling and counter bank
`timescale 1ns/1ps
`default_nettype none
`include "frsc_consts.vh"
module tb_top;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  logic [7:0] evt [0:5];
  logic [7:0] lost, b;
  logic sig_upd, mon_bit_en, mon_bit, mon_last;
  logic [2:0] sig_port, mon_port;
  logic [4:0] sig_chan, mon_chan;
  logic [3:0] sig_abcd, a4, b4;
  logic [1:0] mode [1:8];
  int err_count, n_compared, cyc, p, k, n, v;
  int cnt [1:8][0:5];

  frsc_top #(.NPORTS(8)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
    .line_code_viol_evt(evt[0]), .path_code_viol_evt(evt[1]), .sync_loss_frame_evt(evt[2]),
    .ebit_evt(evt[3]), .far_end_a_evt(evt[4]), .far_end_b_evt(evt[5]),
    .frame_sync_lost(lost), .sig_upd, .sig_port, .sig_chan, .sig_abcd, .mon_bit_en,
    .mon_port, .mon_chan, .mon_bit, .mon_last);
  frsc_line_model i_line (.hclk, .evt, .frame_sync_lost(lost), .sig_upd, .sig_port,
    .sig_chan, .sig_abcd, .mon_bit_en, .mon_port, .mon_chan, .mon_bit, .mon_last);

  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      final_report;
    end
  end

  function automatic logic [31:0] adr(input int p, input int idx);
    return 32'(4 * (32'h200 * (p - 1) + idx));
  endfunction

  // One single AHB-Lite transfer; waits for hready, never assumes latency
  task automatic bus(input logic w, input int p, input int idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= adr(p, idx);
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input int p, input int idx, input logic [7:0] exp);
    bus(1'b0, p, idx, 32'h0000_0000, d);
    chk(d, {24'h00_0000, exp});
  endtask

  task automatic wr(input int p, input int idx, input logic [7:0] val);
    bus(1'b1, p, idx, {24'h00_0000, val}, d);
  endtask

  // Hi byte first, so the lo read comes from the same snapshot
  task automatic rd_cnt(input int p, input int k);
    rdc(p, `FRSC_IDX_LCV_HI + 2 * k, 8'(cnt[p][k] >> 8));
    rdc(p, `FRSC_IDX_LCV_LO + 2 * k, 8'(cnt[p][k]));
  endtask

  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    v = $urandom(32'h1741);
    for (k = 0; k < 12; k++) begin
      rdc(1, `FRSC_IDX_LCV_HI + k, 8'h00);
      rdc(8, `FRSC_IDX_LCV_HI + k, 8'h00);
    end
    rdc(8, `FRSC_IDX_MON, 8'h00);
    rdc(2, 'h61, 8'h00);
    // Random bursts; E-bits only count on ports in E1 mode
    for (p = 1; p <= 8; p++) begin
      mode[p] = 2'($urandom_range(0, 3));
      wr(p, `FRSC_IDX_CTL, {6'h00, mode[p]});
      for (k = 0; k < 6; k++) cnt[p][k] = 0;
    end
    repeat (16) begin
      p = $urandom_range(1, 8);
      k = $urandom_range(0, 5);
      n = $urandom_range(1, 600);
      i_line.burst(k, p, n);
      if (k != 3 || mode[p][0]) cnt[p][k] += n;
      rd_cnt(p, k);
    end
    // Snapshot across a burst, then a lone lo read is live
    v = cnt[6][0];
    rdc(6, `FRSC_IDX_LCV_HI, 8'(v >> 8));
    i_line.burst(0, 6, 300);
    cnt[6][0] += 300;
    rdc(6, `FRSC_IDX_LCV_LO, 8'(v));
    rdc(6, `FRSC_IDX_LCV_LO, 8'(cnt[6][0]));
    wr(6, `FRSC_IDX_LCV_LO, 8'hff);
    for (p = 1; p <= 8; p++) for (k = 0; k < 6; k++) rd_cnt(p, k);
    // Masked event keeps irq low, unmasked one raises it; host polls well inside 1.5ms
    bus(1'b0, 1, `FRSC_IDX_INT_STAT, 32'h0000_0000, d);
    wr(1, `FRSC_IDX_INT_MASK, 8'h02);
    wr(3, `FRSC_IDX_CTL, 8'h00);
    i_line.sig(3, 1, 4'b1100);
    i_line.sig(3, 13, 4'b0110);
    rdc(3, `FRSC_IDX_SIG_BASE, 8'hf5);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(2, `FRSC_IDX_CTL, 8'h02);
    a4 = 4'($urandom);
    b4 = 4'($urandom);
    i_line.sig(2, 5, a4);
    i_line.sig(2, 17, b4);
    rdc(2, `FRSC_IDX_SIG_BASE + 4, {a4, b4});
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(1, `FRSC_IDX_INT_STAT, 8'h06);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    // E1 layout, then frozen while frame sync is lost
    wr(4, `FRSC_IDX_CTL, 8'h01);
    i_line.sig(4, 0, 4'hf);
    i_line.sig(4, 1, 4'h3);
    i_line.sig(4, 16, 4'hc);
    i_line.sig(4, 15, 4'h9);
    i_line.sig(4, 30, 4'h6);
    rdc(4, `FRSC_IDX_SIG_BASE, 8'h0f);
    rdc(4, `FRSC_IDX_SIG_BASE + 1, 8'h3c);
    rdc(4, `FRSC_IDX_SIG_BASE + 15, 8'h96);
    i_line.set_lost(4, 1'b1);
    i_line.sig(4, 1, 4'h5);
    rdc(4, `FRSC_IDX_SIG_BASE + 1, 8'h3c);
    i_line.set_lost(4, 1'b0);
    i_line.sig(4, 1, 4'h5);
    rdc(4, `FRSC_IDX_SIG_BASE + 1, 8'h5c);
    // Monitor ignores other channels, keeps the selected one
    wr(5, `FRSC_IDX_CHSEL, 8'h07);
    i_line.mon(5, 9, 8'h5a);
    rdc(5, `FRSC_IDX_MON, 8'h00);
    b = 8'($urandom);
    i_line.mon(5, 7, b);
    rdc(5, `FRSC_IDX_MON, b);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
